/* logic/cpx_exec_core.sv */
// Operation
// RULE1 - Destination bit 0 writes accumulator, 1 writes the file register
// RULE2 - Watchdog clear zeroes counter and prescaler, sets both status flags
// RULE3 - Invert file, result to destination, zero flag only
// RULE4 - Decrement file, result to destination, carry, half carry, zero
// RULE5 - Skip forms keep flags; zero result flushes next instruction
// RULE6 - Jump loads nine immediate bits plus three page bits, two cycles
// RULE7 - Increment file, result to destination, carry, half carry, zero
// RULE8 - Immediate OR, XOR, load into accumulator; OR forms set zero
// RULE9 - File OR and XOR to destination, zero flag only
// RULE10 - Copy file to destination, zero flag from value moved
// RULE11 - Store accumulator into file, one cycle, flags unchanged
// RULE12 - Option load copies accumulator, one cycle, no flags
// RULE13 - Return loads immediate into accumulator, pops stack, two cycles
// RULE14 - Rotate left through carry, only carry changes
// RULE15 - Rotate right through carry, only carry changes
// RULE16 - Sleep clears power-down, sets timeout, clears watchdog, halts core
// RULE17 - Subtract file minus accumulator by complement add, carry, zero; code also updates half carry
// RULE18 - Nibble exchange to destination, no flags
// RULE19 - Direction load copies accumulator to ports 5 to 7 only
// RULE20 - Watchdog runs on own oscillator, expiry resets, fuse disables
// RULE21 - Unprescaled period 18 ms, prescaler up to 1:128 from option
// RULE22 - Watchdog expiry clears the timeout flag
// RULE23 - Instruction cycle is four clocks; flushed cycles add one more
`timescale 1ns/1ps
module cpx_exec_core #(
  parameter int WDT_OSC_KHZ = cpx_pkg::WDT_OSC_KHZ
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic [11:0]             instrWord,
  input  wire logic [7:0]              fileRdData,
  input  wire logic [2:0]              pageSel,
  input  wire logic [11:0]             stackHead,
  input  wire logic                    wdtOscIn,
  input  wire logic                    wdtFuseEn,
  output logic      [11:0]             progAddr_q,
  output cpx_pkg::cpx_file_t           filePort_q,
  output logic      [7:0]              accum_q,
  output cpx_pkg::cpx_flags_t          flags_q,
  output logic      [7:0]              option_q,
  output logic      [3*8-1:0]          port_direction_load_op_q,
  output logic                         stackPop_q,
  output logic                         sleeping_q,
  output logic                         wdtReset_q
);

  // ****************************************************************
  // Parameter checks and watchdog sizing
  // ****************************************************************
  localparam int WDT_TICKS = cpx_pkg::WDT_PERIOD_US * WDT_OSC_KHZ / 1000;
  localparam int WDT_CW    = $clog2(WDT_TICKS + 1);

  if (WDT_TICKS < 2)
    $error("watchdog oscillator too slow for the period");

  // ****************************************************************
  // Sequencing state
  // ****************************************************************
  cpx_pkg::cpx_phase_t phase_q;
  logic [11:0]         instr_q;
  logic                flush_q;
  logic                execEn;

  // ****************************************************************
  // Decode outputs
  // ****************************************************************
  logic [7:0]  res;
  logic [7:0]  lit;
  logic [5:0]  op6;
  logic        dBit;
  logic        wrW;
  logic        wrF;
  logic        updZ;
  logic        updC;
  logic        updDC;
  logic        newC;
  logic        newDC;
  logic        skipOp;
  logic        jump;
  logic [11:0] target;
  logic        loadOpt;
  logic        loadTris;
  logic [1:0]  trisIdx;
  logic        wdtClr;
  logic        goSleep;
  logic        pop;
  logic [7:0]  addB;
  logic        addCin;
  logic [8:0]  sum;
  logic [4:0]  nib;

  // Watchdog signals
  logic              oscS1_q;
  logic              oscS2_q;
  logic              oscS3_q;
  logic              fuseS1_q;
  logic              fuseS2_q;
  logic [6:0]        presc_q;
  logic [WDT_CW-1:0] wdtCnt_q;
  logic [7:0]        psRatio;
  logic [6:0]        presLast;
  logic              tick;

  assign lit  = instr_q[7:0];
  assign op6  = instr_q[11:6];
  assign dBit = instr_q[cpx_pkg::DEST_BIT];
  assign sum  = {1'b0, fileRdData} + {1'b0, addB} + {8'h00, addCin};
  assign nib  = {1'b0, fileRdData[3:0]} + {1'b0, addB[3:0]}
              + {4'h0, addCin};
  assign execEn = (phase_q == cpx_pkg::PH_Q4) && !flush_q && !sleeping_q
                  && !wdtReset_q;

  // ****************************************************************
  // Shared adder operand selection
  // ****************************************************************
  always_comb
  begin
    addB   = ~accum_q;
    addCin = 1'b1;
    if (op6 == cpx_pkg::OP6_DEC || op6 == cpx_pkg::OP6_DECSKIP)
    begin
      addB   = 8'hff;
      addCin = 1'b0;
    end
    else if (op6 == cpx_pkg::OP6_INC || op6 == cpx_pkg::OP6_INCSKIP)
    begin
      addB   = 8'h00;
      addCin = 1'b1;
    end
  end

  // ****************************************************************
  // Instruction decode and execute
  // ****************************************************************
  always_comb
  begin
    res      = 8'h00;
    wrW      = 1'b0;
    wrF      = 1'b0;
    updZ     = 1'b0;
    updC     = 1'b0;
    updDC    = 1'b0;
    newC     = sum[8];
    newDC    = nib[4];
    skipOp   = 1'b0;
    jump     = 1'b0;
    target   = progAddr_q;
    loadOpt  = 1'b0;
    loadTris = 1'b0;
    trisIdx  = 2'(instr_q[2:0] - 3'(cpx_pkg::CTL_PORT0));
    wdtClr   = 1'b0;
    goSleep  = 1'b0;
    pop      = 1'b0;
    if (instr_q[11:9] == cpx_pkg::OP3_JUMP)
    begin
      jump   = 1'b1;                                           // RULE6
      target = {pageSel, instr_q[cpx_pkg::JUMP_W-1:0]};        // RULE6
    end
    else if (instr_q[11])
    begin
      unique case (instr_q[11:8])
        cpx_pkg::OP4_RETURN:
        begin
          res    = lit;                                        // RULE13
          wrW    = 1'b1;
          jump   = 1'b1;
          pop    = 1'b1;
          target = stackHead;                                  // RULE13
        end
        cpx_pkg::OP4_LOAD:
        begin
          res = lit;                                           // RULE8
          wrW = 1'b1;
        end
        cpx_pkg::OP4_OR:
        begin
          res  = accum_q | lit;                                // RULE8
          wrW  = 1'b1;
          updZ = 1'b1;
        end
        cpx_pkg::OP4_XOR:
        begin
          res  = accum_q ^ lit;                                // RULE8
          wrW  = 1'b1;
          updZ = 1'b1;
        end
        default:
          res = 8'h00;
      endcase
    end
    else
    begin
      wrW = !dBit;                                             // RULE1
      wrF = dBit;                                              // RULE1
      unique case (op6)
        cpx_pkg::OP6_CTRL:
        begin
          wrW = 1'b0;
          wrF = dBit;
          res = accum_q;                                       // RULE11
          if (!dBit)
          begin
            unique case (instr_q[4:0])
              cpx_pkg::CTL_OPTION: loadOpt = 1'b1;             // RULE12
              cpx_pkg::CTL_SLEEP:
              begin
                wdtClr  = 1'b1;                                // RULE16
                goSleep = 1'b1;                                // RULE16
              end
              cpx_pkg::CTL_WDCLR: wdtClr = 1'b1;               // RULE2
              default:
                loadTris = instr_q[4:0] >= cpx_pkg::CTL_PORT0
                  && instr_q[4:0] < 5'(cpx_pkg::CTL_PORT0
                  + 5'(cpx_pkg::PORT_COUNT));                  // RULE19
            endcase
          end
        end
        cpx_pkg::OP6_SUB:
        begin
          res   = sum[7:0];                                    // RULE17
          updZ  = 1'b1;
          updC  = 1'b1;
          updDC = 1'b1;
        end
        cpx_pkg::OP6_DEC, cpx_pkg::OP6_INC:
        begin
          res   = sum[7:0];                                    // RULE4 RULE7
          updZ  = 1'b1;
          updC  = 1'b1;
          updDC = 1'b1;
        end
        cpx_pkg::OP6_DECSKIP, cpx_pkg::OP6_INCSKIP:
        begin
          res    = sum[7:0];
          skipOp = 1'b1;                                       // RULE5
        end
        cpx_pkg::OP6_OR:
        begin
          res  = accum_q | fileRdData;                         // RULE9
          updZ = 1'b1;
        end
        cpx_pkg::OP6_XOR:
        begin
          res  = accum_q ^ fileRdData;                         // RULE9
          updZ = 1'b1;
        end
        cpx_pkg::OP6_COPY:
        begin
          res  = fileRdData;                                   // RULE10
          updZ = 1'b1;
        end
        cpx_pkg::OP6_INV:
        begin
          res  = ~fileRdData;                                  // RULE3
          updZ = 1'b1;
        end
        cpx_pkg::OP6_RL:
        begin
          res  = {fileRdData[6:0], flags_q.c};                 // RULE14
          newC = fileRdData[7];
          updC = 1'b1;
        end
        cpx_pkg::OP6_RR:
        begin
          res  = {flags_q.c, fileRdData[7:1]};                 // RULE15
          newC = fileRdData[0];
          updC = 1'b1;
        end
        cpx_pkg::OP6_SWAP:
          res = {fileRdData[3:0], fileRdData[7:4]};            // RULE18
        default:
        begin
          wrW = 1'b0;
          wrF = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Phase, fetch and program counter
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    stackPop_q <= 1'b0;
    if (sys_rst || wdtReset_q)
    begin
      phase_q    <= cpx_pkg::PH_Q1;
      progAddr_q <= cpx_pkg::RESET_VEC;
      instr_q    <= 12'h000;
      flush_q    <= 1'b1;
    end
    else if (!sleeping_q)
    begin
      phase_q <= cpx_pkg::cpx_phase_t'(phase_q + 2'h1);        // RULE23
      if (phase_q == cpx_pkg::PH_Q4)
      begin
        instr_q <= instrWord;
        flush_q <= execEn && (jump || (skipOp && res == 8'h00)); // RULE5
        stackPop_q <= execEn && pop;                           // RULE13
        if (execEn && jump)
          progAddr_q <= target;                                // RULE6
        else
          progAddr_q <= progAddr_q + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || wdtReset_q)
      sleeping_q <= 1'b0;
    else if (execEn && goSleep)
      sleeping_q <= 1'b1;                                      // RULE16
  end

  // ****************************************************************
  // File port: address in Q2..Q4, write strobe in the next Q1
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      filePort_q <= '0;
    else
    begin
      filePort_q.wr <= execEn && wrF;                          // RULE1
      if (phase_q == cpx_pkg::PH_Q1)
        filePort_q.addr <= instr_q[cpx_pkg::FADDR_W-1:0];
      if (execEn)
        filePort_q.data <= res;
    end
  end

  // ****************************************************************
  // Accumulator, option and flags
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      accum_q <= 8'h00;
    else if (execEn && wrW)
      accum_q <= res;                                          // RULE1
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || wdtReset_q)
      option_q <= cpx_pkg::OPT_RESET;
    else if (execEn && loadOpt)
      option_q <= accum_q;                                     // RULE12
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      flags_q <= cpx_pkg::FLAGS_RESET;
    else if (wdtReset_q)
      flags_q.to <= 1'b0;                                      // RULE22
    else if (execEn)
    begin
      if (updZ)
        flags_q.z <= (res == 8'h00);
      if (updC)
        flags_q.c <= newC;
      if (updDC)
        flags_q.dc <= newDC;
      if (wdtClr)
      begin
        flags_q.to <= 1'b1;                                    // RULE2
        flags_q.pd <= !goSleep;                                // RULE16
      end
    end
  end

  // ****************************************************************
  // Port direction latches
  // ****************************************************************
  for (genvar g = 0; g < cpx_pkg::PORT_COUNT; g++)
  begin : gTris
    always_ff @(posedge mclk)
    begin
      if (sys_rst || wdtReset_q)
        port_direction_load_op_q[g*8 +: 8] <= cpx_pkg::PORT_DIRECTION_LOAD_OP_RESET;
      else if (execEn && loadTris && trisIdx == 2'(g))
        port_direction_load_op_q[g*8 +: 8] <= accum_q;                           // RULE19
    end
  end

  // ****************************************************************
  // Watchdog on its own oscillator, sampled through two flops
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      oscS1_q  <= 1'b0;
      oscS2_q  <= 1'b0;
      oscS3_q  <= 1'b0;
      fuseS1_q <= 1'b0;
      fuseS2_q <= 1'b0;
    end
    else
    begin
      oscS1_q  <= wdtOscIn;                                    // RULE20
      oscS2_q  <= oscS1_q;
      oscS3_q  <= oscS2_q;
      fuseS1_q <= wdtFuseEn;
      fuseS2_q <= fuseS1_q;
    end
  end

  assign tick     = oscS2_q && !oscS3_q;
  assign psRatio  = 8'h01 << option_q[cpx_pkg::OPT_PS_MSB:0];
  assign presLast = option_q[cpx_pkg::OPT_PSA]
                  ? 7'(psRatio - 8'h01) : 7'h00;               // RULE21

  always_ff @(posedge mclk)
  begin
    wdtReset_q <= 1'b0;
    if (sys_rst || wdtReset_q || !fuseS2_q || (execEn && wdtClr))
    begin
      presc_q  <= 7'h00;                                       // RULE2 RULE16
      wdtCnt_q <= '0;                                          // RULE20
    end
    else if (tick)
    begin
      if (presc_q >= presLast)
      begin
        presc_q <= 7'h00;
        if (wdtCnt_q == WDT_CW'(WDT_TICKS - 1))
        begin
          wdtCnt_q   <= '0;
          wdtReset_q <= 1'b1;                                  // RULE20
        end
        else
          wdtCnt_q <= wdtCnt_q + WDT_CW'(1);                   // RULE21
      end
      else
        presc_q <= presc_q + 7'h01;
    end
  end

endmodule

/* logic/cpx_pkg.sv */
package cpx_pkg;

  // ****************************************************************
  // Widths and fields
  // ****************************************************************
  localparam int          DATA_W     = 8;
  localparam int          INSTR_W    = 12;
  localparam int          PC_W       = 12;
  localparam int          FADDR_W    = 5;
  localparam int          DEST_BIT   = 5;
  localparam int          PAGE_W     = 3;
  localparam int          JUMP_W     = 9;
  localparam logic [11:0] RESET_VEC  = 12'hfff;

  // ****************************************************************
  // Byte-oriented opcodes, instruction bits 11:6
  // ****************************************************************
  localparam logic [5:0] OP6_CTRL    = 6'h00;
  localparam logic [5:0] OP6_SUB     = 6'h02;
  localparam logic [5:0] OP6_DEC     = 6'h03;
  localparam logic [5:0] OP6_OR      = 6'h04;
  localparam logic [5:0] OP6_XOR     = 6'h06;
  localparam logic [5:0] OP6_COPY    = 6'h08;
  localparam logic [5:0] OP6_INV     = 6'h09;
  localparam logic [5:0] OP6_INC     = 6'h0a;
  localparam logic [5:0] OP6_DECSKIP = 6'h0b;
  localparam logic [5:0] OP6_RR      = 6'h0c;
  localparam logic [5:0] OP6_RL      = 6'h0d;
  localparam logic [5:0] OP6_SWAP    = 6'h0e;
  localparam logic [5:0] OP6_INCSKIP = 6'h0f;

  // Literal opcodes, bits 11:8, and the jump prefix, bits 11:9
  localparam logic [3:0] OP4_RETURN  = 4'h8;
  localparam logic [3:0] OP4_LOAD    = 4'hc;
  localparam logic [3:0] OP4_OR      = 4'hd;
  localparam logic [3:0] OP4_XOR     = 4'hf;
  localparam logic [2:0] OP3_JUMP    = 3'h5;

  // Control group, bits 4:0 when bits 11:5 are zero
  localparam logic [4:0] CTL_NOP     = 5'h00;
  localparam logic [4:0] CTL_OPTION  = 5'h02;
  localparam logic [4:0] CTL_SLEEP   = 5'h03;
  localparam logic [4:0] CTL_WDCLR   = 5'h04;
  localparam logic [4:0] CTL_PORT0   = 5'h05;
  localparam int         PORT_COUNT  = 3;

  // ****************************************************************
  // Option register and reset values
  // ****************************************************************
  localparam int         OPT_PSA     = 3;
  localparam int         OPT_PS_MSB  = 2;
  localparam logic [7:0] OPT_RESET   = 8'hff;
  localparam logic [7:0] PORT_DIRECTION_LOAD_OP_RESET  = 8'hff;

  // ****************************************************************
  // Watchdog timing
  // ****************************************************************
  localparam int         WDT_PERIOD_US = 18000;
  localparam int         WDT_OSC_KHZ   = 100;
  localparam int         WDT_PS_MAX    = 128;

  typedef struct packed {
    logic to;
    logic pd;
    logic z;
    logic dc;
    logic c;
  } cpx_flags_t;

  localparam cpx_flags_t FLAGS_RESET = '{to: 1'b1, pd: 1'b1,
                                         z: 1'b0, dc: 1'b0, c: 1'b0};

  typedef struct packed {
    logic [4:0] addr;
    logic       wr;
    logic [7:0] data;
  } cpx_file_t;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cpx_phase_t;

endpackage

/* bench/cpx_exec_core_sva.sv */
`timescale 1ns/1ps
module cpx_exec_core_sva #(
  parameter int WDT_OSC_KHZ = cpx_pkg::WDT_OSC_KHZ
) (
  input wire logic                mclk,
  input wire logic                sys_rst,
  input wire logic [11:0]         instrWord,
  input wire logic [7:0]          fileRdData,
  input wire logic [2:0]          pageSel,
  input wire logic [11:0]         stackHead,
  input wire logic                wdtOscIn,
  input wire logic                wdtFuseEn,
  input wire logic [11:0]         progAddr_q,
  input wire cpx_pkg::cpx_file_t  filePort_q,
  input wire logic [7:0]          accum_q,
  input wire cpx_pkg::cpx_flags_t flags_q,
  input wire logic [7:0]          option_q,
  input wire logic [23:0]         port_direction_load_op_q,
  input wire logic                stackPop_q,
  input wire logic                sleeping_q,
  input wire logic                wdtReset_q
);
  // ********************
  // Helper logic
  // ********************
  logic       wdtSeen_q;
  logic [2:0] fuseLow_q;

  always_ff @(posedge mclk)
  begin
    wdtSeen_q <= wdtReset_q;
    if (sys_rst || wdtFuseEn)
      fuseLow_q <= 3'h0;
    else if (fuseLow_q != 3'h7)
      fuseLow_q <= fuseLow_q + 3'h1;
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  pc_cadence_a: assert property (
    disable iff (sys_rst || wdtReset_q || wdtSeen_q)
    $changed(progAddr_q) |=> $stable(progAddr_q) [*3])
    else $error("program counter moved inside an instruction cycle");
  return_target_a: assert property (
    stackPop_q |-> ##[0:3] (progAddr_q == stackHead))
    else $error("return did not load the stack head");
  pop_pulse_a: assert property (stackPop_q |=> !stackPop_q)
    else $error("stack pop longer than one cycle");
  write_pulse_a: assert property (
    filePort_q.wr |=> !filePort_q.wr [*3])
    else $error("file write pulse too long or too close");
  sleep_hold_a: assert property (
    disable iff (sys_rst || wdtReset_q || wdtSeen_q)
    sleeping_q |=> sleeping_q && $stable(progAddr_q) && $stable(accum_q))
    else $error("core moved while halted");
  sleep_flags_a: assert property (
    disable iff (sys_rst || wdtReset_q || wdtSeen_q)
    sleeping_q |-> !flags_q.pd && flags_q.to)
    else $error("wrong status flags while halted");
  pd_fall_a: assert property (
    $fell(flags_q.pd) |-> ##[0:1] sleeping_q)
    else $error("power-down flag cleared without halting");
  wdt_pulse_a: assert property (wdtReset_q |=> !wdtReset_q)
    else $error("watchdog reset pulse too long");
  expiry_flag_a: assert property (
    wdtReset_q |=> !flags_q.to && !sleeping_q)
    else $error("expiry left timeout flag or halt");
  fuse_off_a: assert property ((fuseLow_q == 3'h7) |-> !wdtReset_q)
    else $error("watchdog expired with fuse off");
endmodule

bind cpx_exec_core cpx_exec_core_sva #(
  .WDT_OSC_KHZ (WDT_OSC_KHZ)
) i_cpx_exec_core_sva (
  .mclk (mclk), .sys_rst (sys_rst), .instrWord (instrWord),
  .fileRdData (fileRdData), .pageSel (pageSel), .stackHead (stackHead),
  .wdtOscIn (wdtOscIn), .wdtFuseEn (wdtFuseEn), .progAddr_q (progAddr_q),
  .filePort_q (filePort_q), .accum_q (accum_q), .flags_q (flags_q),
  .option_q (option_q), .port_direction_load_op_q (port_direction_load_op_q), .stackPop_q (stackPop_q),
  .sleeping_q (sleeping_q), .wdtReset_q (wdtReset_q)
);

/* bench/cpx_mem_model.sv */
`timescale 1ns/1ps
module cpx_mem_model (
  input wire logic                mclk,
  input wire logic [11:0]         progAddr,
  input wire cpx_pkg::cpx_file_t  filePort,
  output logic [11:0]             instrWord,
  output logic [7:0]              fileRdData
);
  // ********************
  // Program and file storage
  // ********************
  logic [11:0] prog [0:4095];
  logic [7:0]  fram [0:31];

  assign instrWord  = prog[progAddr];
  assign fileRdData = fram[filePort.addr];

  always @(posedge mclk)
  begin
    if (filePort.wr === 1'b1)
      fram[filePort.addr] <= filePort.data;
  end
endmodule

/* bench/cpx_exec_core_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("[ERR] %0t got %h expected %h", $time, (a), (b)); \
    end \
  end

module cpx_exec_core_bench;
  localparam int LIMIT = 5000;
  logic                mclk;
  logic                sys_rst;
  logic [11:0]         instrWord;
  logic [7:0]          fileRdData;
  logic [2:0]          pageSel;
  logic [11:0]         stackHead;
  logic                wdtOscIn;
  logic                wdtFuseEn;
  logic [11:0]         progAddr_q;
  cpx_pkg::cpx_file_t  filePort_q;
  logic [7:0]          accum_q;
  cpx_pkg::cpx_flags_t flags_q;
  logic [7:0]          option_q;
  logic [23:0]         port_direction_load_op_q;
  logic                stackPop_q;
  logic                sleeping_q;
  logic                wdtReset_q;
  logic [1:0]          oscDiv;
  int                  err_count;
  int                  n_compared;
  int                  cycleCnt;
  int                  wdtHits;

  cpx_exec_core #(
    .WDT_OSC_KHZ (1)
  ) i_cpx_exec_core (
    .mclk (mclk), .sys_rst (sys_rst), .instrWord (instrWord),
    .fileRdData (fileRdData), .pageSel (pageSel), .stackHead (stackHead),
    .wdtOscIn (wdtOscIn), .wdtFuseEn (wdtFuseEn), .progAddr_q (progAddr_q),
    .filePort_q (filePort_q), .accum_q (accum_q), .flags_q (flags_q),
    .option_q (option_q), .port_direction_load_op_q (port_direction_load_op_q), .stackPop_q (stackPop_q),
    .sleeping_q (sleeping_q), .wdtReset_q (wdtReset_q)
  );

  cpx_mem_model i_cpx_mem_model (
    .mclk (mclk), .progAddr (progAddr_q), .filePort (filePort_q),
    .instrWord (instrWord), .fileRdData (fileRdData)
  );

  // ********************
  // Clock, watchdog oscillator, timeout
  // ********************
  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    oscDiv <= oscDiv + 2'h1;
    if (oscDiv == 2'h3)
      wdtOscIn <= ~wdtOscIn;
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == LIMIT)
    begin
      err_count++;
      stop_test();
    end
  end

  always @(negedge mclk)
  begin
    if (wdtReset_q === 1'b1)
      wdtHits++;
  end

  // ********************
  // Helpers
  // ********************
  function automatic logic [11:0] fo(logic [5:0] op, logic d, logic [4:0] f);
    return {op, d, f};
  endfunction

  function automatic logic [11:0] fl(logic [3:0] op, logic [7:0] k);
    return {op, k};
  endfunction

  task automatic load(int a, logic [11:0] w);
    i_cpx_mem_model.prog[a] = w;
  endtask

  task automatic clr();
    @(posedge mclk);
    sys_rst <= 1'b1;
    for (int i = 0; i < 4096; i++)
      i_cpx_mem_model.prog[i] = 12'h000;
    for (int i = 0; i < 32; i++)
      i_cpx_mem_model.fram[i] = 8'h00;
  endtask

  task automatic run(int n);
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic sleep_prog();
    load(0, fl(cpx_pkg::OP4_LOAD, 8'h08));
    load(1, {7'h00, cpx_pkg::CTL_OPTION});
    load(2, {7'h00, cpx_pkg::CTL_SLEEP});
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_logic();
    clr();
    i_cpx_mem_model.fram[17] = 8'h5a;
    load(0, fl(cpx_pkg::OP4_LOAD, 8'h3c));
    load(1, fo(cpx_pkg::OP6_CTRL, 1'b1, 5'h10));
    load(2, fl(cpx_pkg::OP4_OR, 8'h03));
    load(3, fo(cpx_pkg::OP6_XOR, 1'b0, 5'h10));
    load(4, fo(cpx_pkg::OP6_INV, 1'b1, 5'h10));
    load(5, fo(cpx_pkg::OP6_COPY, 1'b0, 5'h10));
    load(6, fl(cpx_pkg::OP4_XOR, 8'hc0));
    load(7, fo(cpx_pkg::OP6_OR, 1'b1, 5'h11));
    run(60);
    `CHK(accum_q, 8'h03)
    `CHK(i_cpx_mem_model.fram[16], 8'hc3)
    `CHK(i_cpx_mem_model.fram[17], 8'h5b)
    `CHK(flags_q, 5'h18)
    $display("t_logic done");
  endtask

  task automatic t_arith();
    clr();
    load(0, fo(cpx_pkg::OP6_DEC, 1'b1, 5'h12));
    load(1, fo(cpx_pkg::OP6_INC, 1'b0, 5'h12));
    load(2, fl(cpx_pkg::OP4_LOAD, 8'h01));
    load(3, fo(cpx_pkg::OP6_SUB, 1'b1, 5'h12));
    load(4, fo(cpx_pkg::OP6_RL, 1'b1, 5'h12));
    load(5, fo(cpx_pkg::OP6_RR, 1'b0, 5'h12));
    load(6, fo(cpx_pkg::OP6_SWAP, 1'b1, 5'h12));
    run(60);
    `CHK(accum_q, 8'hfe)
    `CHK(i_cpx_mem_model.fram[18], 8'hdf)
    `CHK(flags_q, 5'h1b)
    $display("t_arith done");
  endtask

  task automatic t_flow();
    clr();
    pageSel <= 3'h1;
    stackHead <= 12'h300;
    i_cpx_mem_model.fram[19] = 8'h01;
    load(0, fo(cpx_pkg::OP6_DECSKIP, 1'b1, 5'h13));
    // Skipped slot: a direction load of port 5 that must not land
    load(1, {7'h00, 5'h05});
    load(2, fl(cpx_pkg::OP4_LOAD, 8'h20));
    load(3, {7'h00, cpx_pkg::CTL_OPTION});
    load(4, {7'h00, 5'h06});
    load(5, {cpx_pkg::OP3_JUMP, 9'h040});
    load(6, fl(cpx_pkg::OP4_LOAD, 8'h77));
    load(12'h240, fo(cpx_pkg::OP6_INCSKIP, 1'b0, 5'h13));
    load(12'h241, fl(cpx_pkg::OP4_RETURN, 8'h5a));
    load(12'h242, fl(cpx_pkg::OP4_LOAD, 8'h99));
    load(12'h300, fl(cpx_pkg::OP4_XOR, 8'hff));
    run(80);
    `CHK(accum_q, 8'ha5)
    `CHK(option_q, 8'h20)
    `CHK(port_direction_load_op_q, 24'hff20ff)
    `CHK(i_cpx_mem_model.fram[19], 8'h00)
    `CHK(flags_q, 5'h18)
    $display("t_flow done");
  endtask

  task automatic t_sleep();
    int n;
    int h0;
    clr();
    pageSel <= 3'h0;
    sleep_prog();
    run(4);
    for (n = 0; n < 100 && sleeping_q !== 1'b1; n++)
      @(negedge mclk);
    `CHK(sleeping_q, 1'b1)
    `CHK(flags_q, 5'h10)
    for (n = 0; n < 400 && wdtReset_q !== 1'b1; n++)
      @(negedge mclk);
    `CHK(n inside {[128:176]}, 1'b1)
    load(2, {7'h00, cpx_pkg::CTL_WDCLR});
    load(3, {cpx_pkg::OP3_JUMP, 9'h002});
    @(negedge mclk);
    `CHK(flags_q, 5'h00)
    `CHK(sleeping_q, 1'b0)
    h0 = wdtHits;
    repeat (600) @(negedge mclk);
    `CHK(flags_q, 5'h18)
    `CHK(wdtHits - h0, 0)
    $display("t_sleep done");
  endtask

  task automatic t_fuse();
    int h0;
    clr();
    wdtFuseEn <= 1'b0;
    sleep_prog();
    h0 = wdtHits;
    run(500);
    `CHK(wdtHits - h0, 0)
    `CHK(sleeping_q, 1'b1)
    @(posedge mclk);
    wdtFuseEn <= 1'b1;
    $display("t_fuse done");
  endtask

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    pageSel = 3'h0;
    stackHead = 12'h300;
    wdtOscIn = 1'b0;
    wdtFuseEn = 1'b1;
    oscDiv = 2'h0;
    err_count = 0;
    n_compared = 0;
    cycleCnt = 0;
    wdtHits = 0;
    t_logic();
    t_arith();
    t_flow();
    t_sleep();
    t_fuse();
    stop_test();
  end
endmodule
